// ==== core/ipc_pkg.sv ====
package ipc_pkg;
	// data bus field positions
	localparam int ROT_BIT = 7;
	localparam int SL_BIT = 6;
	localparam int EOI_BIT = 5;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 3;
	localparam int LVL_HI = 2;
	localparam int ESMM_BIT = 6;
	localparam int SMM_BIT = 5;
	localparam int RR_BIT = 1;
	localparam int RIS_BIT = 0;
	localparam logic [1:0] SEL_OP_COMMAND_TWO = 2'h0;
	localparam logic [1:0] SEL_OP_COMMAND_THREE = 2'h1;
	// call opcode released on the first pulse in single or master 8-bit mode
	localparam logic [7:0] CALL_OPCODE = 8'hCD;
	localparam logic [7:0] RESET_MASK = 8'h00;
	localparam logic [2:0] RESET_LOWEST = 3'h7;
	localparam logic [1:0] ACK_FIRST = 2'h0;
	localparam logic [1:0] ACK_SECOND = 2'h1;
	localparam logic [1:0] ACK_LAST_8BIT = 2'h2;
	// host spacing figures in ns, kept for reference by the bench
	localparam int ACK_GAP_NS = 625;
	localparam int CMD_GAP_NS = 500;
	localparam int CLK_NS = 10;
	localparam int ACK_GAP_CYC = (ACK_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CMD_GAP_CYC = (CMD_GAP_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic [7:0] in_service_bits;
		logic [7:0] mask_bits;
		logic [2:0] lowest;
		logic rot_auto_end_of_interrupt;
		logic read_isr;
		logic special_mask;
		logic [1:0] ack_cnt;
		logic [2:0] ack_level;
		logic [7:0] dout;
		logic dout_en;
		logic [2:0] wr_s;
		logic [2:0] ack_s;
	} ipc_state_type;
endpackage

// ==== core/ipc_core.sv ====
// How it works
// R1 - rotate non-specific clear: top bit, lowest priority
// R2 - rotate specific clear: named level lowest
// R3 - rotate-only word sets auto rotate flag
// R4 - all-zero word clears auto rotate flag
// R5 - rotate specific without clear: priority only
// R6 - 16-bit mode: float first, pointer next
// R7 - single 8-bit mode: drive every pulse
// R8 - 8-bit master: call first, float after
// R9 - slave: float first, address bytes after
// R10 - host waits 625 ns between sequences
// R11 - host waits 500 ns between commands
// R12 - non-specific clear hits highest in-service bit
// R13 - auto clear at last pulse trailing edge
// R14 - read select holds until next selection
// R15 - special mask spares masked in-service bits
// R16 - bits four-three pick command two or three
// R17 - high address write loads mask bits
`timescale 1ns/1ps
module ipc_core
	import ipc_pkg::*;
(
	input wire logic clk_i, // 100 MHz clock
	input wire logic nrst_i, // sync reset, low active
	input wire logic wr_n_i, // write strobe pin
	input wire logic ack_pulse_n_i, // acknowledge strobe pin
	input wire logic address_bit_zero_i, // address bit zero
	input wire logic [7:0] data_i, // data bus in
	input wire logic initialized_i, // init words done
	input wire logic mode16_i, // 16-bit processor mode
	input wire logic cascade_i, // cascaded system
	input wire logic master_i, // cascade master
	input wire logic auto_end_of_interrupt_i, // auto clear mode
	input wire logic [7:0] pending_request_bits_i, // pending requests
	input wire logic [7:0] vector_byte1_i, // first vector byte / pointer
	input wire logic [7:0] vector_byte2_i, // second vector byte
	input wire logic [2:0] ack_level_i, // level chosen for this ack
	input wire logic set_in_service_i, // mark ack_level_i in service
	output logic [7:0] data_o, // data bus out
	output logic data_oe_n_o, // low while driving
	output logic [7:0] in_service_bits_o, // in-service bits
	output logic [7:0] mask_bits_o, // mask bits
	output logic [7:0] status_o, // selected status read byte
	output logic [2:0] lowest_level_o, // lowest priority level
	output logic rot_auto_end_of_interrupt_o // auto rotate flag
);
	ipc_state_type state_reg, state_next;

	// highest-priority set bit scanning up from lowest+1
	function automatic logic [3:0] top_bit(input logic [7:0] bits, input logic [2:0] low);
		logic [3:0] r;
		logic [2:0] idx;
		r = 4'h8;
		for (int k = 7; k >= 0; k--)
		begin
			idx = 3'(low + 3'(k) + 3'h1);
			if (bits[idx])
				r = {1'b0, idx};
		end
		return r;
	endfunction

	logic wr_rise, ack_fall, ack_rise, last_pulse;
	logic [7:0] clearable;
	logic [3:0] top;
	logic [2:0] lvl;

	always_comb
	begin
		state_next = state_reg;
		// synchronisers: bit 0 is first stage, read only by the shift
		state_next.wr_s = {state_reg.wr_s[1:0], wr_n_i};
		state_next.ack_s = {state_reg.ack_s[1:0], ack_pulse_n_i};
		wr_rise = state_reg.wr_s[1] & ~state_reg.wr_s[2];
		ack_fall = ~state_reg.ack_s[1] & state_reg.ack_s[2];
		ack_rise = state_reg.ack_s[1] & ~state_reg.ack_s[2];
		// R15 special mask protection
		clearable = state_reg.special_mask ? state_reg.in_service_bits & ~state_reg.mask_bits : state_reg.in_service_bits;
		// R12 highest set bit
		top = top_bit(clearable, state_reg.lowest);
		lvl = data_i[LVL_HI:0];
		last_pulse = (mode16_i || !cascade_i || !master_i) ?
			(state_reg.ack_cnt == (mode16_i ? ACK_SECOND : ACK_LAST_8BIT)) :
			(state_reg.ack_cnt == ACK_LAST_8BIT);

		if (wr_rise)
		begin
			if (address_bit_zero_i)
			begin
				// R17 mask load
				if (initialized_i)
					state_next.mask_bits = data_i;
			end
			// R16 command select
			else if (data_i[SEL_HI:SEL_LO] == SEL_OP_COMMAND_TWO)
			begin
				unique case ({data_i[ROT_BIT], data_i[SL_BIT], data_i[EOI_BIT]})
					3'h1:
						// R12 non-specific clear
						if (!top[3])
							state_next.in_service_bits[top[2:0]] = 1'b0;
					3'h3:
						if (clearable[lvl])
							state_next.in_service_bits[lvl] = 1'b0;
					3'h5:
						// R1 clear and rotate
						if (!top[3])
						begin
							state_next.in_service_bits[top[2:0]] = 1'b0;
							state_next.lowest = top[2:0];
						end
					3'h7:
					begin
						// R2 specific clear and rotate
						if (clearable[lvl])
							state_next.in_service_bits[lvl] = 1'b0;
						state_next.lowest = lvl;
					end
					3'h4:
						// R3 set auto rotate
						state_next.rot_auto_end_of_interrupt = 1'b1;
					3'h0:
						// R4 clear auto rotate
						state_next.rot_auto_end_of_interrupt = 1'b0;
					3'h6:
						// R5 priority only
						state_next.lowest = lvl;
					3'h2:
						state_next.lowest = state_reg.lowest;
				endcase
			end
			else if (data_i[SEL_HI:SEL_LO] == SEL_OP_COMMAND_THREE)
			begin
				// R14 selection persists
				if (data_i[RR_BIT])
					state_next.read_isr = data_i[RIS_BIT];
				if (data_i[ESMM_BIT])
					state_next.special_mask = data_i[SMM_BIT];
			end
		end

		if (ack_fall)
		begin
			state_next.ack_level = ack_level_i;
			state_next.dout_en = 1'b0;
			state_next.dout = 8'h00;
			if (mode16_i)
			begin
				// R6 float then pointer
				if (state_reg.ack_cnt != ACK_FIRST)
				begin
					state_next.dout_en = 1'b1;
					state_next.dout = vector_byte1_i;
				end
			end
			else if (!cascade_i)
			begin
				// R7 drive every pulse
				state_next.dout_en = 1'b1;
				state_next.dout = (state_reg.ack_cnt == ACK_FIRST) ? CALL_OPCODE :
					(state_reg.ack_cnt == ACK_SECOND) ? vector_byte1_i : vector_byte2_i;
			end
			else if (master_i)
			begin
				// R8 call then float
				if (state_reg.ack_cnt == ACK_FIRST)
				begin
					state_next.dout_en = 1'b1;
					state_next.dout = CALL_OPCODE;
				end
			end
			else if (state_reg.ack_cnt != ACK_FIRST)
			begin
				// R9 float then address bytes
				state_next.dout_en = 1'b1;
				state_next.dout = (state_reg.ack_cnt == ACK_SECOND) ?
					vector_byte1_i : vector_byte2_i;
			end
		end

		if (ack_rise)
		begin
			state_next.dout_en = 1'b0;
			state_next.ack_cnt = 2'(state_reg.ack_cnt + 2'h1);
			if (last_pulse)
			begin
				state_next.ack_cnt = ACK_FIRST;
				// R13 auto clear at trailing edge; R10 host spacing assumed
				if (auto_end_of_interrupt_i && !top[3])
				begin
					state_next.in_service_bits[top[2:0]] = 1'b0;
					if (state_reg.rot_auto_end_of_interrupt)
						state_next.lowest = top[2:0];
				end
			end
		end

		// set placed after the clears so a new service mark beats a same-cycle clear
		if (set_in_service_i)
			state_next.in_service_bits[ack_level_i] = 1'b1;

		if (!nrst_i)
		begin
			state_next = '0;
			state_next.mask_bits = RESET_MASK;
			state_next.lowest = RESET_LOWEST;
			state_next.wr_s = 3'h7;
			state_next.ack_s = 3'h7;
		end
	end

	always_ff @(posedge clk_i)
	begin
		state_reg <= state_next;
	end

	assign data_o = state_reg.dout;
	assign data_oe_n_o = ~state_reg.dout_en;
	assign in_service_bits_o = state_reg.in_service_bits;
	assign mask_bits_o = state_reg.mask_bits;
	assign status_o = state_reg.read_isr ? state_reg.in_service_bits : pending_request_bits_i;
	assign lowest_level_o = state_reg.lowest;
	assign rot_auto_end_of_interrupt_o = state_reg.rot_auto_end_of_interrupt;
endmodule

// ==== sim/ipc_checker.sv ====
`timescale 1ns/1ps
module ipc_checker
	import ipc_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic nrst_i, // reset
	input wire logic wr_n_i, // write pin
	input wire logic ack_pulse_n_i, // ack pin
	input wire logic address_bit_zero_i, // a0
	input wire logic [7:0] data_i, // bus in
	input wire logic mode16_i, // mode
	input wire logic cascade_i, // cascade
	input wire logic master_i, // master
	input wire logic [7:0] pending_request_bits_i, // pending
	input wire logic [7:0] vector_byte1_i, // byte one
	input wire logic [7:0] vector_byte2_i, // byte two
	input wire logic [7:0] data_o, // bus out
	input wire logic data_oe_n_o, // drive low
	input wire logic [7:0] in_service_bits_o, // isr
	input wire logic [7:0] mask_bits_o, // mask
	input wire logic [7:0] status_o, // status
	input wire logic [2:0] lowest_level_o, // lowest
	input wire logic rot_auto_end_of_interrupt_o // flag
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic drv = !data_oe_n_o;
	logic [2:0] ws;
	logic rsel;
	// own copy of the read selection, same sync depth as the pin path
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ws <= 3'h7;
			rsel <= 1'b0;
		end
		else
		begin
			ws <= {ws[1:0], wr_n_i};
			if (ws[1] && !ws[2] && !address_bit_zero_i && data_i[SEL_HI:SEL_LO] == SEL_OP_COMMAND_THREE
				&& data_i[RR_BIT])
				rsel <= data_i[RIS_BIT];
		end
	end
	reset_idle_a: assert property ($rose(nrst_i) |-> data_oe_n_o
		&& mask_bits_o == RESET_MASK && lowest_level_o == RESET_LOWEST) else $error("not idle");
	// host holds the bus long past the update, so current data is the cause
	mask_load_a: assert property ($changed(mask_bits_o) |->
		address_bit_zero_i && mask_bits_o == data_i) else $error("bad mask");
	rot_flag_a: assert property ($changed(rot_auto_end_of_interrupt_o) |->
		!address_bit_zero_i && rot_auto_end_of_interrupt_o == data_i[ROT_BIT]) else $error("bad flag");
	status_sel_a: assert property (status_o == (rsel ? in_service_bits_o :
		pending_request_bits_i)) else $error("bad status");
	drive_window_a: assert property (drv |-> !$past(ack_pulse_n_i, 2) ||
		!$past(ack_pulse_n_i, 6)) else $error("drive outside ack");
	wide_ptr_a: assert property (drv && mode16_i |-> data_o == vector_byte1_i)
		else $error("bad pointer");
	master_call_a: assert property (drv && cascade_i && master_i && !mode16_i |->
		data_o == CALL_OPCODE) else $error("bad call");
	slave_vec_a: assert property (drv && cascade_i && !master_i |->
		data_o == vector_byte1_i || data_o == vector_byte2_i) else $error("bad vector");
endmodule
bind ipc_core ipc_checker chk_u (.*);

// ==== sim/ipc_host.sv ====
`timescale 1ns/1ps
module ipc_host
	import ipc_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic [8:0] q_i, // enable and byte
	output logic wr_n_o = 1'b1, // write pin
	output logic ack_n_o = 1'b1, // ack pin
	output logic a0_o = 1'b0, // a0
	output logic [7:0] d_o = 8'h00 // bus
);
	task automatic wr(input logic a, input logic [7:0] c);
		@(negedge clk_i);
		{a0_o, d_o, wr_n_o} = {a, c, 1'b0};
		repeat (3) @(negedge clk_i);
		wr_n_o = 1'b1;
		repeat (CMD_GAP_CYC) @(negedge clk_i);
		// released bus must not show a stale byte
		d_o = ~c;
	endtask
	task automatic ack(input int n, output logic [8:0] r[3]);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_i);
			ack_n_o = 1'b0;
			repeat (8) @(negedge clk_i);
			r[i] = q_i;
			ack_n_o = 1'b1;
			repeat (8) @(negedge clk_i);
		end
		repeat (ACK_GAP_CYC) @(negedge clk_i);
	endtask
endmodule

// ==== sim/ipc_core_tb_top.sv ====
`timescale 1ns/1ps
module ipc_core_tb_top;
	import ipc_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, m16 = 1'b0, cas = 1'b0, mst = 1'b0, auto_end_of_interrupt = 1'b0, set = 1'b0;
	logic wr_n, ack_n, a0, oe_n, rot;
	logic [2:0] lvl = 3'h0, low;
	logic [7:0] pending_request_bits = 8'h00, v1 = 8'h00, v2 = 8'h00, d, dout, in_service_bits, mask_bits, st;
	logic [31:0] tmp;
	logic [8:0] e[3], r[3];
	logic [2:0] md[5] = '{3'h4, 3'h0, 3'h3, 3'h2, 3'h0};
	int fails = 0, checks_done = 0, seed = 32'h312122d3;
	int m_isr = 0, m_imr = 0, m_low = 7, m_rot = 0, m_rsel = 0, m_smm = 0;
	always #5 clk = ~clk;
	ipc_host h (.clk_i(clk), .q_i({oe_n, dout}), .wr_n_o(wr_n), .ack_n_o(ack_n),
		.a0_o(a0), .d_o(d));
	ipc_core uut (.clk_i(clk), .nrst_i(nrst), .wr_n_i(wr_n), .ack_pulse_n_i(ack_n),
		.address_bit_zero_i(a0), .data_i(d), .initialized_i(1'b1), .mode16_i(m16),
		.cascade_i(cas), .master_i(mst), .auto_end_of_interrupt_i(auto_end_of_interrupt),
		.pending_request_bits_i(pending_request_bits), .vector_byte1_i(v1), .vector_byte2_i(v2),
		.ack_level_i(lvl), .set_in_service_i(set), .data_o(dout), .data_oe_n_o(oe_n),
		.in_service_bits_o(in_service_bits), .mask_bits_o(mask_bits), .status_o(st), .lowest_level_o(low),
		.rot_auto_end_of_interrupt_o(rot));
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checks_done++;
		if (x !== g)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic cmp();
		chk("isr", m_isr[7:0], in_service_bits);
		chk("mask", m_imr[7:0], mask_bits);
		chk("lowest", 8'(m_low), {5'h0, low});
		chk("flag", 8'(m_rot), {7'h0, rot});
		chk("status", m_rsel[0] ? m_isr[7:0] : pending_request_bits, st);
	endtask
	function automatic int m_top();
		for (int i = 1; i < 9; i++)
			if (m_isr[(m_low + i) % 8])
				return (m_low + i) % 8;
		return -1;
	endfunction
	task automatic m_cmd(input logic [7:0] c);
		int l;
		l = c[6] ? int'(c[2:0]) : m_top();
		if (c[5] && l >= 0 && !(m_smm && m_imr[l]))
			m_isr[l] = 0;
		if (c[7] && c[6:5] != 2'h0 && l >= 0)
			m_low = l;
		if (c[6:5] == 2'h0)
			m_rot = c[7];
	endtask
	task automatic w(input logic a, input logic [7:0] c);
		h.wr(a, c);
		if (a)
			m_imr = c;
		else if (c[4:3] == 2'h1)
		begin
			m_rsel = c[1] ? c[0] : m_rsel;
			m_smm = c[6] ? c[5] : m_smm;
		end
		else if (c[4:3] == 2'h0)
			m_cmd(c);
		cmp();
	endtask
	task automatic si(input logic [2:0] l);
		@(negedge clk);
		{lvl, set} = {l, 1'b1};
		@(negedge clk);
		set = 1'b0;
		m_isr[l] = 1;
	endtask
	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		cmp();
		tmp = $random(seed);
		pending_request_bits = tmp[15:8];
		w(1'b1, tmp[7:0]);
		si(3'h1);
		si(tmp[18:16]);
		si(3'h6);
		w(1'b0, 8'h0B);
		w(1'b0, 8'h20);
		w(1'b0, 8'hA0);
		si(3'h2);
		w(1'b0, 8'hE2);
		w(1'b0, 8'hC5);
		w(1'b0, 8'h0A);
		pending_request_bits = ~pending_request_bits;
		w(1'b0, 8'h80);
		w(1'b0, 8'h00);
		w(1'b0, 8'h18);
		w(1'b1, 8'h10);
		si(3'h4);
		w(1'b0, 8'h68);
		w(1'b0, 8'h64);
		w(1'b0, 8'h48);
		w(1'b0, 8'h64);
		for (int k = 0; k < 5; k++)
		begin
			tmp = $random(seed);
			{v1, v2} = tmp[15:0];
			{m16, cas, mst} = md[k];
			if (k == 4)
			begin
				w(1'b0, 8'h80);
				si(3'h5);
				auto_end_of_interrupt = 1'b1;
			end
			e[0] = m16 || (cas && !mst) ? 9'h100 : {1'b0, CALL_OPCODE};
			e[1] = cas && mst && !m16 ? 9'h100 : {1'b0, v1};
			e[2] = cas && mst ? 9'h100 : {1'b0, v2};
			h.ack(m16 ? 2 : 3, r);
			for (int i = 0; i < 3 - m16; i++)
			begin
				chk("float", {7'h0, e[i][8]}, {7'h0, r[i][8]});
				if (!e[i][8])
					chk("ack byte", e[i][7:0], r[i][7:0]);
			end
			if (auto_end_of_interrupt)
				m_cmd(m_rot[0] ? 8'hA0 : 8'h20);
			cmp();
		end
		end_sim();
	end
endmodule
